// ---- hdl/pwmc_pkg.sv ----
// Package of constants for the pulse width channel with period counter
package pwmc_pkg;
  // ----------------------------------------------------------------
  // Register map, word offsets in bytes
  // ----------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_PERIOD    = 8'h04;
  localparam logic [7:0]  ADDR_DUTY      = 8'h08;
  localparam logic [7:0]  ADDR_UPDATE    = 8'h0C;
  localparam logic [7:0]  ADDR_STATUS    = 8'h10;
  localparam logic [7:0]  ADDR_COUNT     = 8'h14;
  localparam logic [7:0]  ADDR_PRESCALE  = 8'h18;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int          CTRL_EN_BIT    = 0;
  localparam int          CTRL_CENTER_ALIGN_SELECT_BIT  = 1;
  localparam int          CTRL_UPSEL_BIT = 2;
  localparam int          STAT_ENF_BIT   = 0;
  localparam int          STAT_EVT_BIT   = 1;
  localparam int          CNT_W          = 20;
  // ----------------------------------------------------------------
  // Reset and restart values
  // ----------------------------------------------------------------
  localparam logic [19:0] CNT_FIRST      = 20'h0_0000;
  localparam logic [19:0] CNT_RELOAD     = 20'h0_0001;
  localparam logic [19:0] PERIOD_RST     = 20'h0_0000;
  localparam logic [19:0] DUTY_RST       = 20'h0_0000;
  localparam logic [19:0] ZERO_VALUE     = 20'h0_0000;
  localparam logic [7:0]  PRESCALE_RST   = 8'h00;
  localparam logic [31:0] UNMAPPED_DATA  = 32'h0000_0000;
endpackage : pwmc_pkg

// ---- hdl/pwmc_tick.sv ----
// Channel clock tick divider
`timescale 1ns/100ps
module pwmc_tick #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         run,
  input  wire logic [W-1:0] divide,
  output logic              tick
);
  import pwmc_pkg::*;
  logic [W-1:0] div_ff;
  logic [W-1:0] nxt_div;
  wire          div_end = (div_ff == divide);

  // Tick when the divider reaches its programmed count
  assign tick    = run & div_end;
  assign nxt_div = (!run || div_end) ? '0 : W'(div_ff + 1'b1);

  // ----------------------------------------------------------------
  // Divider register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_ff <= '0;
    end else begin
      div_ff <= nxt_div;
    end
  end
endmodule : pwmc_tick

// ---- hdl/pwmc_channel.sv ----
// Pulse width channel with period counter and Avalon-MM slave
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
module pwmc_channel #(
  parameter int CW = pwmc_pkg::CNT_W,
  parameter int PW = 8
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  output logic             pwm_out,
  output logic             channel_event
);
  import pwmc_pkg::*;

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic       rst_meta_ff;
  logic       rst_ff;
  // Two flip-flops release the asynchronous reset on a clock edge,
  // so that no register leaves reset a cycle before the others
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_ff      <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_ff      <= rst_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic          enable_ff;
  logic          center_align_select_ff;
  logic          upd_sel_duty_ff;
  logic [CW-1:0] period_ff;
  logic [CW-1:0] duty_ff;
  logic [CW-1:0] channel_update_value_ff;
  logic          upd_pend_ff;
  logic [PW-1:0] prescale_ff;
  logic [CW-1:0] cnt_ff;
  logic          down_ff;
  logic          first_ff;
  logic          channel_enabled_flag_ff;
  logic          event_ff;
  logic          ack_ff;
  logic [31:0]   rdata_ff;
  logic          pwm_ff;

  // Bus decode; every access waits one cycle, then completes at the edge
  // where waitrequest reads low; writes and read side effects land there,
  // while read data are captured one edge earlier so they stand when taken
  wire           req      = (avs_read | avs_write) & ~ack_ff;
  wire           wr       = avs_write & ack_ff;
  wire           rd       = avs_read & ~ack_ff;
  wire           rd_done  = avs_read & ack_ff;
  wire           wr_ctrl  = wr & (avs_address == ADDR_CTRL) & avs_byteenable[0];
  wire           wr_per   = wr & (avs_address == ADDR_PERIOD);
  wire           wr_duty  = wr & (avs_address == ADDR_DUTY);
  wire           wr_upd   = wr & (avs_address == ADDR_UPDATE);
  wire           wr_pre   = wr & (avs_address == ADDR_PRESCALE) & avs_byteenable[0];
  wire           rd_stat  = rd_done & (avs_address == ADDR_STATUS);
  wire           ev_seen  = rd_stat & rdata_ff[STAT_EVT_BIT];
  wire [CW-1:0]  wval     = avs_writedata[CW-1:0];
  wire           en_set   = wr_ctrl & avs_writedata[CTRL_EN_BIT] & ~enable_ff;
  wire           en_clr   = wr_ctrl & ~avs_writedata[CTRL_EN_BIT] & enable_ff;
  wire           center_align_select_new = wr_ctrl ? avs_writedata[CTRL_CENTER_ALIGN_SELECT_BIT] : center_align_select_ff;

  assign avs_waitrequest = (avs_read | avs_write) & ~ack_ff;
  assign avs_readdata    = rdata_ff;
  assign pwm_out         = pwm_ff;
  assign channel_event   = event_ff;

  // Ticks run while enabled and through the period after a disable;
  // an enable restarts the divider so the first period is complete
  wire  wind_down = first_ff & ~enable_ff;
  wire  tick_run  = (enable_ff | wind_down) & ~en_set;

  // Channel clock tick
  logic tick;
  pwmc_tick #(.W(PW)) u_tick (
    .clk    (clk),
    .rst_n  (rst_ff),
    .run    (tick_run),
    .divide (prescale_ff),
    .tick   (tick)
  );

  // Period end detection and counter movement
  wire at_top     = (cnt_ff == period_ff);
  wire at_bottom  = (cnt_ff == ZERO_VALUE) | (cnt_ff == CNT_RELOAD);
  wire left_end   = tick & ~center_align_select_ff & at_top;
  wire center_end = tick & center_align_select_ff & down_ff & at_bottom;
  wire period_end = left_end | center_end;
  wire upd_ok     = upd_pend_ff & (upd_sel_duty_ff | (channel_update_value_ff != ZERO_VALUE));

  // Next count: restart on enable, reload on wrap, else step up or down
  logic [CW-1:0] nxt_cnt;
  logic          nxt_down;
  always_comb begin
    nxt_cnt  = cnt_ff;
    nxt_down = down_ff;
    if (en_set) begin
      nxt_cnt  = CNT_FIRST;
      nxt_down = 1'b0;
    end else if (tick) begin
      if (period_end) begin
        nxt_cnt  = CNT_RELOAD;
        nxt_down = 1'b0;
      end else if (center_align_select_ff && at_top) begin
        nxt_down = 1'b1;
        nxt_cnt  = CW'(cnt_ff - 1'b1);
      end else if (down_ff) begin
        nxt_cnt  = CW'(cnt_ff - 1'b1);
      end else begin
        nxt_cnt  = CW'(cnt_ff + 1'b1);
      end
    end
  end

  // Enable status lags a disable until the running period has ended;
  // software must not trust it earlier
  wire nxt_enf   = en_set | (channel_enabled_flag_ff & (enable_ff | (wind_down & ~period_end)));
  wire nxt_first = en_clr | (wind_down & ~period_end & ~en_set);

  // Event: set on period end or center-aligned enable; a status read
  // clears only an event it has returned, and a new set wins
  wire ev_set  = period_end | (en_set & center_align_select_new);
  wire nxt_ev  = ev_set | (event_ff & ~ev_seen);

  // Read data selection
  // Captured when a read first appears, returned one edge later
  logic [31:0] rsel;
  always_comb begin
    rsel = UNMAPPED_DATA;
    unique case (avs_address)
      ADDR_CTRL:     rsel = {29'h0, upd_sel_duty_ff, center_align_select_ff, enable_ff};
      ADDR_PERIOD:   rsel = {{(32-CW){1'b0}}, period_ff};
      ADDR_DUTY:     rsel = {{(32-CW){1'b0}}, duty_ff};
      ADDR_UPDATE:   rsel = {{(32-CW){1'b0}}, channel_update_value_ff};
      ADDR_STATUS:   rsel = {30'h0, event_ff, channel_enabled_flag_ff};
      ADDR_COUNT:    rsel = {{(32-CW){1'b0}}, cnt_ff};
      ADDR_PRESCALE: rsel = {{(32-PW){1'b0}}, prescale_ff};
      default:       rsel = UNMAPPED_DATA;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus and configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_ff) begin
    if (!rst_ff) begin
      ack_ff                 <= 1'b0;
      rdata_ff               <= UNMAPPED_DATA;
      enable_ff              <= 1'b0;
      center_align_select_ff <= 1'b0;
      upd_sel_duty_ff        <= 1'b0;
      prescale_ff            <= PRESCALE_RST;
    end else begin
      ack_ff   <= req;
      rdata_ff <= rd ? rsel : rdata_ff;
      if (wr_ctrl) begin
        enable_ff              <= avs_writedata[CTRL_EN_BIT];
        center_align_select_ff <= avs_writedata[CTRL_CENTER_ALIGN_SELECT_BIT];
        upd_sel_duty_ff        <= avs_writedata[CTRL_UPSEL_BIT];
      end
      if (wr_pre) begin
        prescale_ff <= avs_writedata[PW-1:0];
      end
    end
  end

  // Period, duty and pending update; update lands at period end
  // A zero period update is dropped, yet the pending mark still clears
  always_ff @(posedge clk or negedge rst_ff) begin
    if (!rst_ff) begin
      period_ff               <= PERIOD_RST;
      duty_ff                 <= DUTY_RST;
      channel_update_value_ff <= ZERO_VALUE;
      upd_pend_ff             <= 1'b0;
    end else begin
      if (wr_per && !enable_ff) begin
        period_ff <= wval;
      end else if (period_end && upd_ok && !upd_sel_duty_ff) begin
        period_ff <= channel_update_value_ff;
      end
      if (wr_duty && !enable_ff) begin
        duty_ff <= wval;
      end else if (period_end && upd_ok && upd_sel_duty_ff) begin
        duty_ff <= channel_update_value_ff;
      end
      if (wr_upd) begin
        channel_update_value_ff <= wval;
      end
      upd_pend_ff <= wr_upd | (upd_pend_ff & ~period_end);
    end
  end

  // Counter, status and output
  // Output stays low while winding down after a disable
  always_ff @(posedge clk or negedge rst_ff) begin
    if (!rst_ff) begin
      cnt_ff                  <= CNT_FIRST;
      down_ff                 <= 1'b0;
      first_ff                <= 1'b0;
      channel_enabled_flag_ff <= 1'b0;
      event_ff                <= 1'b0;
      pwm_ff                  <= 1'b0;
    end else begin
      cnt_ff                  <= nxt_cnt;
      down_ff                 <= nxt_down;
      first_ff                <= nxt_first;
      channel_enabled_flag_ff <= nxt_enf;
      event_ff                <= nxt_ev;
      pwm_ff                  <= enable_ff & (cnt_ff < duty_ff);
    end
  end
endmodule : pwmc_channel

// ---- dv/pwmc_channel_sva.sv ----
// Checker for bus timing, enable event and period lengths of the channel
`timescale 1ns/100ps
module pwmc_channel_sva
  import pwmc_pkg::*;
#(parameter int CW = CNT_W, parameter int PW = 8) (
  input wire logic        clk,
  input wire logic        arst_n,
  input wire logic [7:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        pwm_out,
  input wire logic        channel_event
);
  logic [CW-1:0] per_ff;
  logic [PW-1:0] pre_ff;
  logic [31:0]   gap_ff;
  logic [1:0]    nr_ff;
  logic          en_ff;
  logic          ca_ff;
  // Completed writes and expected period lengths in clocks
  wire        wr      = avs_write && !avs_waitrequest;
  wire        ctl     = wr && avs_address == ADDR_CTRL && avs_byteenable[0];
  wire [31:0] t_first = (32'(per_ff) + 1) * (32'(pre_ff) + 1);
  wire [31:0] t_next  = 32'(per_ff) * (32'(pre_ff) + 1);
  // Shadow of control, period, prescale and gap between output rises
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {per_ff, pre_ff, gap_ff, nr_ff, en_ff, ca_ff} <= '0;
    end else begin
      gap_ff <= $rose(pwm_out) ? 32'h0000_0001 : gap_ff + 1;
      if ($rose(pwm_out) && nr_ff != 2'h2) nr_ff <= nr_ff + 2'h1;
      if (ctl) begin
        {ca_ff, en_ff} <= avs_writedata[1:0];
        nr_ff <= 2'h0;
      end
      if (wr && avs_address == ADDR_PERIOD && !en_ff) per_ff <= avs_writedata[CW-1:0];
      if (ctl && avs_address == ADDR_PRESCALE) pre_ff <= avs_writedata[PW-1:0];
      if (wr && avs_address == ADDR_PRESCALE && avs_byteenable[0]) pre_ff <= avs_writedata[PW-1:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  idle_nowait_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  en_event_a: assert property (ctl && avs_writedata[1:0] == 2'b11 && !en_ff |-> ##[1:3] channel_event)
    else $error("no event on center enable");
  first_per_a: assert property ($rose(pwm_out) && nr_ff == 2'h1 && !ca_ff |-> gap_ff == t_first)
    else $error("first period length wrong");
  later_per_a: assert property ($rose(pwm_out) && nr_ff == 2'h2 && !ca_ff |-> gap_ff == t_next)
    else $error("later period length wrong");
  unmapped_rd_a: assert property (avs_read && !avs_waitrequest && avs_address == 8'h1C |-> avs_readdata == UNMAPPED_DATA)
    else $error("unmapped read not zero");
endmodule // pwmc_channel_sva

bind pwmc_channel pwmc_channel_sva #(.CW(CW), .PW(PW)) u_sva (.clk(clk), .arst_n(arst_n),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .pwm_out(pwm_out), .channel_event(channel_event));

// ---- dv/pwm_channel_period_counter_tb.sv ----
// Self-checking bench for the pulse width channel
`timescale 1ns/100ps
module pwm_channel_period_counter_tb;
  import pwmc_pkg::*;
  logic        clk, arst_n, avs_read, avs_write, avs_waitrequest, pwm_out, channel_event, pw_q;
  logic [7:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic [3:0]  avs_byteenable;
  logic [7:0]  addrs [7] = '{ADDR_CTRL, ADDR_PERIOD, ADDR_DUTY, ADDR_STATUS, ADDR_COUNT, ADDR_PRESCALE, 8'h1C};
  int          n_fail, n_checks, seed, cyc, p, k;
  int          rises[$];
  pwmc_channel uut (.clk(clk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pwm_out(pwm_out),
    .channel_event(channel_event));
  always #4 clk = ~clk;
  // Cycle stamps of each output rise
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (pwm_out === 1'b1 && pw_q !== 1'b1) rises.push_back(cyc);
    pw_q <= pwm_out;
  end
  task summarize;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Bounded wait for the slave to drop waitrequest
  task wt;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      n_fail++;
      $display("CHECK FAILED at %0t: bus timeout", $time);
      summarize;
    end
  endtask
  task bw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= 1'b1;
    wt;
    avs_write <= 1'b0;
  endtask
  task br(input logic [7:0] a);
    @(posedge clk);
    avs_address <= a;
    avs_read <= 1'b1;
    wt;
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  initial begin
    {clk, arst_n, avs_read, avs_write, pw_q, avs_address, avs_writedata} = '0;
    avs_byteenable = 4'hF;
    {n_fail, n_checks, cyc} = '0;
    seed = 7;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values, then a write to an unmapped place
    foreach (addrs[i]) begin
      br(addrs[i]);
      chk(rd, 32'h0000_0000);
    end
    bw(8'h1C, 32'hFFFF_FFFF);
    br(8'h1C);
    chk(rd, UNMAPPED_DATA);
    $display("test reset done");
    // Left-aligned runs with random period and prescale, zero update on top
    repeat (3) begin
      p = 12 + {$random(seed)} % 12;
      k = {$random(seed)} % 3;
      bw(ADDR_PERIOD, p);
      bw(ADDR_DUTY, 32'h0000_0002);
      bw(ADDR_PRESCALE, k);
      rises.delete();
      bw(ADDR_CTRL, 32'h0000_0001);
      bw(ADDR_UPDATE, 32'h0000_0000);
      for (int i = 0; i < 4000 && rises.size() < 3; i++) @(posedge clk);
      if (rises.size() < 3) begin
        n_fail++;
        $display("CHECK FAILED at %0t: output rises missing", $time);
        summarize;
      end
      chk(rises[1] - rises[0], (p + 1) * (k + 1));
      chk(rises[2] - rises[1], p * (k + 1));
      bw(ADDR_CTRL, 32'h0000_0000);
      br(ADDR_STATUS);
      chk(rd[0], 32'h0000_0001);
      repeat ((p + 1) * (k + 1) + 8) @(posedge clk);
      br(ADDR_STATUS);
      chk(rd[0], 32'h0000_0000);
      $display("test period %0d prescale %0d done", p, k);
    end
    // Slow tick: count still zero just after enable
    bw(ADDR_PRESCALE, 32'h0000_00FF);
    bw(ADDR_PERIOD, 32'h0000_0064);
    bw(ADDR_CTRL, 32'h0000_0001);
    br(ADDR_COUNT);
    chk(rd, 32'h0000_0000);
    bw(ADDR_CTRL, 32'h0000_0000);
    // Center-aligned enable raises the event; a status read clears it
    br(ADDR_STATUS);
    @(posedge clk);
    chk(channel_event, 32'h0000_0000);
    bw(ADDR_CTRL, 32'h0000_0003);
    repeat (3) @(posedge clk);
    chk(channel_event, 32'h0000_0001);
    br(ADDR_STATUS);
    chk(rd[1], 32'h0000_0001);
    @(posedge clk);
    chk(channel_event, 32'h0000_0000);
    $display("test center event done");
    summarize;
  end
endmodule // pwm_channel_period_counter_tb
